/* File: verilog/rmd_pkg.sv */
package rmd_pkg;
	localparam int unsigned RMD_PORTS = 6;
	localparam int unsigned RMD_CLK_HZ = 100000000;
	localparam int unsigned RMD_SETTLE_MS = 15;
	localparam int unsigned RMD_SETTLE_CYC = RMD_CLK_HZ / 1000 * RMD_SETTLE_MS;
	typedef enum logic [1:0] {
		RMD_MODE_DIRECT,
		RMD_MODE_CLEAR_ALL,
		RMD_MODE_BBM,
		RMD_MODE_MBB
	} rmd_mode_t;
endpackage

/* File: verilog/rmd_timer.sv */
`timescale 1ns/100ps
`default_nettype none
// Down counter: load starts a wait, done pulses when it runs out
module rmd_timer #(
	parameter int unsigned CYCLES = 1500000
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic load,
	output logic busy,
	output logic done
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic done_reg;
	logic done_next;

	always_comb begin
		cnt_next = cnt_reg;
		done_next = 1'b0;
		if (load) begin
			cnt_next = 32'(CYCLES);
		end else if (cnt_reg != 32'h0) begin
			cnt_next = cnt_reg - 32'h1;
			done_next = (cnt_reg == 32'h1);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 32'h0;
			done_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			done_reg <= done_next;
		end
	end

	assign busy = (cnt_reg != 32'h0);
	assign done = done_reg;
endmodule // rmd_timer
`default_nettype wire

/* File: verilog/rmd_ctrl.sv */
// Notes on behaviour
// - Path selects exactly two ports' connect lines
// - Disconnect connected ports outside new path
// - Never connect and disconnect same port
// - No disconnect-all while any connect asserted
// - Direct mode grounds the path's connect lines and every other port's disconnect line
// - Or disconnect-all 15 ms, then connect
// - Break-before-make: deselect, wait 15 ms, select
// - Make-before-break: select, wait 15 ms, deselect
`timescale 1ns/100ps
`default_nettype none
module rmd_ctrl #(
	parameter int unsigned PORTS = rmd_pkg::RMD_PORTS,
	parameter int unsigned SETTLE_CYC = rmd_pkg::RMD_SETTLE_CYC,
	parameter bit HAS_CLEAR_ALL = 1'b1
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic [2:0] req_port_a,
	input wire logic [2:0] req_port_b,
	input wire rmd_pkg::rmd_mode_t req_mode,
	output logic req_ready,
	output logic req_error,
	output logic [PORTS-1:0] path_now,
	input wire logic [PORTS-1:0] conn_in,
	output logic [PORTS-1:0] conn_out,
	output logic [PORTS-1:0] conn_oe,
	input wire logic [PORTS-1:0] disc_in,
	output logic [PORTS-1:0] disc_out,
	output logic [PORTS-1:0] disc_oe,
	input wire logic clear_all_in,
	output logic clear_all_out,
	output logic clear_all_oe
);
	typedef enum logic [2:0] {
		RMD_IDLE,
		RMD_STEP1,
		RMD_STEP2,
		RMD_DONE
	} rmd_state_t;

	rmd_state_t state_reg, state_next;
	logic [PORTS-1:0] conn_reg, conn_next;
	logic [PORTS-1:0] disc_reg, disc_next;
	logic all_reg, all_next;
	logic [PORTS-1:0] want_reg, want_next;
	logic [PORTS-1:0] path_reg, path_next;
	rmd_pkg::rmd_mode_t mode_reg, mode_next;
	logic err_reg, err_next;
	logic tmr_load;
	logic tmr_busy;
	logic tmr_done;
	logic [PORTS-1:0] want_req;
	logic req_ok;
	logic [2*PORTS:0] rb_pin;
	logic [2*PORTS:0] rb_s1_reg, rb_s1_next;
	logic [2*PORTS:0] rb_s2_reg, rb_s2_next;
	logic [2*PORTS:0] rb_s3_reg, rb_s3_next;
	logic lines_free;

	rmd_timer #(
		.CYCLES(SETTLE_CYC)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.load(tmr_load),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// Line readback from the pins passes a three-flop chain; stages two and three are used
	assign rb_pin = {conn_in, disc_in, clear_all_in};
	always_comb begin
		rb_s1_next = rb_pin;
		rb_s2_next = rb_s1_reg;
		rb_s3_next = rb_s2_reg;
	end
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rb_s1_reg <= '1;
			rb_s2_reg <= '1;
			rb_s3_reg <= '1;
		end else begin
			rb_s1_reg <= rb_s1_next;
			rb_s2_reg <= rb_s2_next;
			rb_s3_reg <= rb_s3_next;
		end
	end
	// Released once the last two stages agree high; no new path is
	// started while any line still reads back grounded
	assign lines_free = (&rb_s2_reg) && (&rb_s3_reg);

	// Two distinct ports in range form a path
	always_comb begin
		want_req = '0;
		if (req_port_a < 3'(PORTS)) begin
			want_req[req_port_a] = 1'b1;
		end
		if (req_port_b < 3'(PORTS)) begin
			want_req[req_port_b] = 1'b1;
		end
	end
	assign req_ok = (req_port_a != req_port_b) && (req_port_a < 3'(PORTS))
		&& (req_port_b < 3'(PORTS))
		&& (HAS_CLEAR_ALL || req_mode != rmd_pkg::RMD_MODE_CLEAR_ALL);

	always_comb begin
		state_next = state_reg;
		conn_next = conn_reg;
		disc_next = disc_reg;
		all_next = all_reg;
		want_next = want_reg;
		path_next = path_reg;
		mode_next = mode_reg;
		err_next = err_reg;
		tmr_load = 1'b0;
		case (state_reg)
			RMD_IDLE: begin
				if (req_valid && req_ready) begin
					err_next = !req_ok;
					if (req_ok) begin
						want_next = want_req;
						mode_next = req_mode;
						tmr_load = 1'b1;
						state_next = RMD_STEP1;
						case (req_mode)
							rmd_pkg::RMD_MODE_DIRECT: begin
								conn_next = want_req;
								disc_next = ~want_req;
							end
							rmd_pkg::RMD_MODE_CLEAR_ALL: begin
								conn_next = '0;
								disc_next = '0;
								all_next = 1'b1;
							end
							rmd_pkg::RMD_MODE_BBM: begin
								conn_next = '0;
								disc_next = path_reg & ~want_req;
							end
							default: begin
								conn_next = want_req;
								disc_next = '0;
							end
						endcase
					end
				end
			end
			RMD_STEP1: begin
				if (tmr_done) begin
					case (mode_reg)
						rmd_pkg::RMD_MODE_DIRECT: begin
							conn_next = '0;
							disc_next = '0;
							state_next = RMD_DONE;
						end
						rmd_pkg::RMD_MODE_CLEAR_ALL,
						rmd_pkg::RMD_MODE_BBM: begin
							all_next = 1'b0;
							disc_next = '0;
							conn_next = want_reg;
							tmr_load = 1'b1;
							state_next = RMD_STEP2;
						end
						default: begin
							conn_next = '0;
							disc_next = path_reg & ~want_reg;
							tmr_load = 1'b1;
							state_next = RMD_STEP2;
						end
					endcase
				end
			end
			RMD_STEP2: begin
				if (tmr_done) begin
					conn_next = '0;
					disc_next = '0;
					state_next = RMD_DONE;
				end
			end
			RMD_DONE: begin
				path_next = want_reg;
				state_next = RMD_IDLE;
			end
			default: begin
				state_next = RMD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= RMD_IDLE;
			conn_reg <= '0;
			disc_reg <= '0;
			all_reg <= 1'b0;
			want_reg <= '0;
			path_reg <= '0;
			mode_reg <= rmd_pkg::RMD_MODE_DIRECT;
			err_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			conn_reg <= conn_next;
			disc_reg <= disc_next;
			all_reg <= all_next;
			want_reg <= want_next;
			path_reg <= path_next;
			mode_reg <= mode_next;
			err_reg <= err_next;
		end
	end

	// Open-drain: output level is always low, enable grounds the line
	assign conn_out = '0;
	assign disc_out = '0;
	assign clear_all_out = 1'b0;
	assign conn_oe = conn_reg & ~disc_reg;
	assign disc_oe = disc_reg;
	assign clear_all_oe = all_reg && HAS_CLEAR_ALL && (conn_reg == '0);
	assign req_ready = (state_reg == RMD_IDLE) && !tmr_busy && lines_free;
	assign req_error = err_reg;
	assign path_now = path_reg;
endmodule // rmd_ctrl
`default_nettype wire

/* File: tb/rmd_ctrl_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module rmd_ctrl_assertions #(
	parameter int unsigned SETTLE_CYC = 20
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic req_error,
	input wire logic [2:0] req_port_a,
	input wire logic [2:0] req_port_b,
	input wire logic [5:0] conn_oe,
	input wire logic [5:0] disc_oe,
	input wire logic [5:0] conn_out,
	input wire logic [5:0] disc_out,
	input wire logic clear_all_oe,
	input wire logic clear_all_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	wire logic [12:0] lines = {conn_oe, disc_oe, clear_all_oe};
	int unsigned cnt;
	// Cycles the present line pattern has stood
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n) cnt <= 0;
		else cnt <= $changed(lines) ? 0 : cnt + 1;
	property p_excl; !(|(conn_oe & disc_oe)); endproperty
	a_excl: assert property (p_excl) else $error("port both ways");
	property p_all; clear_all_oe |-> conn_oe == 6'h00; endproperty
	a_all: assert property (p_all) else $error("clear with connect");
	property p_od; conn_out == 6'h00 && disc_out == 6'h00 && !clear_all_out;
	endproperty
	a_od: assert property (p_od) else $error("line driven high");
	property p_two; |conn_oe |-> $countones(conn_oe) == 2; endproperty
	a_two: assert property (p_two) else $error("not two ports");
	property p_idle; req_ready |-> lines == 13'h0000; endproperty
	a_idle: assert property (p_idle) else $error("lines left on");
	property p_go;
		req_valid && req_ready && req_port_a != req_port_b &&
		req_port_a < 3'h6 && req_port_b < 3'h6 |=> lines != 13'h0000;
	endproperty
	a_go: assert property (p_go) else $error("request not driven");
	property p_gap;
		$changed(lines) && $past(lines) != 13'h0000 |-> cnt >= SETTLE_CYC;
	endproperty
	a_gap: assert property (p_gap) else $error("phase too short");
	property p_bad;
		req_valid && req_ready && req_port_a == req_port_b
		|=> req_error && req_ready && lines == 13'h0000;
	endproperty
	a_bad: assert property (p_bad) else $error("bad path taken");
	c_clr: cover property ($rose(clear_all_oe));
	c_err: cover property ($rose(req_error));
	c_busy: cover property ($fell(req_ready));
endmodule // rmd_ctrl_assertions
`default_nettype wire

/* File: tb/rmd_switch_model.sv */
`timescale 1ns/100ps
`default_nettype none
module rmd_switch_model #(
	parameter int T = 150,
	parameter bit HAS_ALL = 1'b1
) (
	input wire logic [5:0] conn_n,
	input wire logic [5:0] disc_n,
	input wire logic all_n,
	output logic [5:0] pos,
	output logic buzz
);
	logic [5:0] open_w;
	initial pos = 6'h00;
	initial buzz = 1'b0;
	// Only grounded lines act; variant without clear ignores it
	assign open_w = ~disc_n | {6{~all_n & HAS_ALL}};
	// Ports move after solenoid time; low position means terminated
	always @(conn_n, open_w) begin
		pos <= #T (pos | ~conn_n) & ~open_w;
	end
	// Lines move in several deltas at an edge; judge settled levels only
	always @(conn_n, open_w) begin
		#1;
		buzz = buzz | ((|(~conn_n & open_w)) === 1'b1);
	end
endmodule // rmd_switch_model
`default_nettype wire

/* File: tb/test_rmd_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module test_rmd_ctrl;
	logic clk_sys = 0;
	logic rst_n = 0;
	logic req_valid = 0;
	logic [2:0] req_port_a = 3'h0;
	logic [2:0] req_port_b = 3'h0;
	rmd_pkg::rmd_mode_t req_mode = rmd_pkg::RMD_MODE_DIRECT;
	logic req_ready, req_error, clear_all_out, clear_all_oe, clear_all_in, buzz;
	logic [5:0] path_now, conn_out, conn_oe, disc_out, disc_oe, pos;
	logic [5:0] conn_in, disc_in;
	int fails = 0;
	int num_checks = 0;
	always #5 clk_sys = ~clk_sys;
	// Pulled-up lines: low only where grounded
	assign conn_in = (conn_out & conn_oe) | ~conn_oe;
	assign disc_in = (disc_out & disc_oe) | ~disc_oe;
	assign clear_all_in = (clear_all_out & clear_all_oe) | ~clear_all_oe;
	rmd_ctrl #(.SETTLE_CYC(20)) uut(.clk_sys, .rst_n, .req_valid,
		.req_port_a, .req_port_b, .req_mode, .req_ready, .req_error,
		.path_now, .conn_in, .conn_out, .conn_oe, .disc_in, .disc_out,
		.disc_oe, .clear_all_in, .clear_all_out, .clear_all_oe);
	rmd_switch_model #(.T(150)) dev(.conn_n(conn_in), .disc_n(disc_in),
		.all_n(clear_all_in), .pos(pos), .buzz(buzz));
	task close_out;
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string n, input logic [12:0] e, input logic [12:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: exp %h got %h", n, e, g);
		end
	endtask
	// One request, first phase sampled, then path and error judged
	task run(input rmd_pkg::rmd_mode_t m, input logic [2:0] a, b,
		input logic [12:0] ph, input logic [5:0] want, input logic e);
		int i;
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_mode <= m;
		req_port_a <= a;
		req_port_b <= b;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		@(posedge clk_sys);
		#1;
		chk("phase1", ph, {conn_oe, disc_oe, clear_all_oe});
		for (i = 0; req_ready !== 1'b1; i++) begin
			if (i == 200) begin
				fails++;
				close_out;
			end
			@(posedge clk_sys);
			#1;
		end
		chk("error", {12'h000, e}, {12'h000, req_error});
		chk("path", {7'h00, want}, {7'h00, path_now});
		chk("position", {7'h00, want}, {7'h00, pos});
	endtask
	task sc_direct;
		run(rmd_pkg::RMD_MODE_DIRECT, 3'h1, 3'h4, 13'h095a, 6'h12, 1'h0);
	endtask
	task sc_bbm;
		run(rmd_pkg::RMD_MODE_BBM, 3'h2, 3'h5, 13'h0024, 6'h24, 1'h0);
	endtask
	task sc_bad;
		run(rmd_pkg::RMD_MODE_MBB, 3'h3, 3'h3, 13'h0000, 6'h24, 1'h1);
		run(rmd_pkg::RMD_MODE_DIRECT, 3'h6, 3'h1, 13'h0000, 6'h24, 1'h1);
	endtask
	task sc_mbb;
		run(rmd_pkg::RMD_MODE_MBB, 3'h0, 3'h3, 13'h0480, 6'h09, 1'h0);
	endtask
	task sc_clr;
		run(rmd_pkg::RMD_MODE_CLEAR_ALL, 3'h5, 3'h2, 13'h0001, 6'h24, 1'h0);
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		rst_n <= 1'b1;
		sc_direct;
		sc_bbm;
		sc_bad;
		sc_mbb;
		sc_clr;
		chk("buzz", 13'h0000, {12'h000, buzz});
		close_out;
	end
endmodule // test_rmd_ctrl
bind rmd_ctrl rmd_ctrl_assertions #(.SETTLE_CYC(SETTLE_CYC)) chk_i(.*);
`default_nettype wire
